// *** include/ptr_defines.vh ***
// Register offsets, bit positions, reset values and default chip identifier for the power/thermal bank.
`ifndef PTR_DEFINES_VH
`define PTR_DEFINES_VH
`define ADDR_RESET_ID 8'h00
`define ADDR_THERMAL 8'h02
`define ADDR_MIXER 8'h03
`define ADDR_ANTIPOP 8'h39
`define ADDR_SEQ 8'h46
`define ADDR_CPUMP 8'h4c
`define ADDR_SERVO 8'h54
`define BIT_SPK_GAIN 8
`define BIT_LHP_MIX 5
`define BIT_RHP_MIX 4
`define BIT_SPK_MIX 3
`define BIT_STARTUP_BIAS 2
`define BIT_RSERVO 1
`define BIT_LSERVO 0
`define BIT_OT_STATUS 15
`define BIT_SENSOR_ON 14
`define BIT_OUTPUT_CUT 13
`define BIT_SEQ_ON 8
`define BIT_CPUMP_ON 15
`define RST_SENSOR_ON 1'b1
`define RST_OUTPUT_CUT 1'b1
`define RST_ENABLE 1'b0
`define CHIP_ID_DEFAULT 16'h5a5a // Arbitrary value, not the code of any real part.
`endif

// *** src/power_thermal_reset_ctrl.v ***
// Power enable, thermal shutdown and software reset register bank.
// Functional notes
// - Speaker gain stage bit 8, speaker mixer bit 3 of mixer register, reset 0.
// - Left and right headphone mixer enables at bits 5 and 4, reset 0.
// - Start-up bias enable at bit 2 of register 39h, reset 0.
// - Right/left offset servo enables at bits 1/0 of register 54h, reset 0.
// - Over-temperature status is read-only bit 15 of register 02h.
// - Sensor runs only while bit 14 set, default 1; status follows sensor.
// - Sensor on and output-cut bit 13 set: over-temperature disables speaker.
// - Any write to register 00h performs a software reset.
// - Register 00h content is read-only; writes do not change it.
// - Reading register 00h returns the fixed chip identifier.
`timescale 1ns/1ns
`include "ptr_defines.vh"
module power_thermal_reset_ctrl #(
  parameter [15:0] CHIP_ID = `CHIP_ID_DEFAULT // Arbitrary identifier value.
) (
  input wire ref_clk, // System clock, 100 MHz.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire wr_en, // Register write strobe, one cycle.
  input wire rd_en, // Register read strobe, one cycle.
  input wire [7:0] reg_addr, // Register address.
  input wire [15:0] wr_data, // Write data.
  output reg [15:0] rd_data, // Read data, registered.
  output reg rd_valid, // Read data valid pulse.
  input wire overtemp_raw, // Raw comparator output from the sensor, asynchronous.
  output wire temp_sensor_on, // Sensor power enable.
  output wire speaker_gain_stage_on, // Speaker gain stage enable.
  output wire speaker_mixer_on, // Speaker mixer enable.
  output wire left_headphone_mixer_on, // Left headphone mixer enable.
  output wire right_headphone_mixer_on, // Right headphone mixer enable.
  output wire startup_bias_on, // Start-up bias enable.
  output wire sequencer_on, // Write sequencer enable.
  output wire charge_pump_on, // Charge pump enable.
  output wire right_offset_servo_on, // Right headphone servo enable.
  output wire left_offset_servo_on, // Left headphone servo enable.
  output wire speaker_out_cut, // High while the speaker output is forced off.
  output wire soft_reset_pulse // One-cycle pulse when software reset happens.
);
  reg sensor_on_r;
  reg output_cut_r;
  reg spk_gain_r;
  reg spk_mix_r;
  reg lhp_mix_r;
  reg rhp_mix_r;
  reg startup_bias_r;
  reg seq_on_r;
  reg cpump_on_r;
  reg rservo_r;
  reg lservo_r;
  reg soft_rst_r;
  wire ot_sync;
  wire overtemp_status;
  wire soft_rst_hit;

  // The sensor comparator is asynchronous to ref_clk, so it passes two flops.
  // Status therefore lags the pin by two edges; the cut is never early.
  sync2 u_ot_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d(overtemp_raw),
    .q(ot_sync)
  );

  // Status and cut are plain gates of flopped terms, so they settle early.
  // status gated by sensor
  assign overtemp_status = sensor_on_r & ot_sync;
  assign speaker_out_cut = overtemp_status & output_cut_r;

  assign soft_rst_hit = wr_en && (reg_addr == `ADDR_RESET_ID);
  // The pulse lets the rest of the device follow a software reset.
  assign soft_reset_pulse = soft_rst_r;

  // Control fields. A software reset restores defaults in the same edge as the
  // write, so no stale enable survives into the next cycle.
  // A write to 00h is never also decoded as a field write.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sensor_on_r <= `RST_SENSOR_ON;
      output_cut_r <= `RST_OUTPUT_CUT;
      spk_gain_r <= `RST_ENABLE;
      spk_mix_r <= `RST_ENABLE;
      lhp_mix_r <= `RST_ENABLE;
      rhp_mix_r <= `RST_ENABLE;
      startup_bias_r <= `RST_ENABLE;
      seq_on_r <= `RST_ENABLE;
      cpump_on_r <= `RST_ENABLE;
      rservo_r <= `RST_ENABLE;
      lservo_r <= `RST_ENABLE;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= soft_rst_hit;
      if (soft_rst_hit) begin
        sensor_on_r <= `RST_SENSOR_ON;
        output_cut_r <= `RST_OUTPUT_CUT;
        spk_gain_r <= `RST_ENABLE;
        spk_mix_r <= `RST_ENABLE;
        lhp_mix_r <= `RST_ENABLE;
        rhp_mix_r <= `RST_ENABLE;
        startup_bias_r <= `RST_ENABLE;
        seq_on_r <= `RST_ENABLE;
        cpump_on_r <= `RST_ENABLE;
        rservo_r <= `RST_ENABLE;
        lservo_r <= `RST_ENABLE;
      end else if (wr_en) begin
        case (reg_addr)
          `ADDR_THERMAL: begin
            // Software should touch these only with the outputs off; the logic
            // accepts them at any time and leaves that order to the driver.
            // sensor enable write
            sensor_on_r <= wr_data[`BIT_SENSOR_ON];
            output_cut_r <= wr_data[`BIT_OUTPUT_CUT];
          end
          `ADDR_MIXER: begin
            spk_gain_r <= wr_data[`BIT_SPK_GAIN];
            spk_mix_r <= wr_data[`BIT_SPK_MIX];
            lhp_mix_r <= wr_data[`BIT_LHP_MIX];
            rhp_mix_r <= wr_data[`BIT_RHP_MIX];
          end
          `ADDR_ANTIPOP: begin
            startup_bias_r <= wr_data[`BIT_STARTUP_BIAS];
          end
          `ADDR_SEQ: begin
            seq_on_r <= wr_data[`BIT_SEQ_ON];
          end
          `ADDR_CPUMP: begin
            cpump_on_r <= wr_data[`BIT_CPUMP_ON];
          end
          `ADDR_SERVO: begin
            rservo_r <= wr_data[`BIT_RSERVO];
            lservo_r <= wr_data[`BIT_LSERVO];
          end
          default: begin
            // Unmapped writes are dropped; holding one field keeps the branch full.
            sensor_on_r <= sensor_on_r;
          end
        endcase
      end
    end
  end

  // Read path. Unmapped addresses read zero; unlisted bits read zero.
  // A read in the same cycle as a write returns the value before it.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= 16'h0000;
        case (reg_addr)
          `ADDR_RESET_ID: begin
            rd_data <= CHIP_ID;
          end
          `ADDR_THERMAL: begin
            rd_data[`BIT_OT_STATUS] <= overtemp_status;
            rd_data[`BIT_SENSOR_ON] <= sensor_on_r;
            rd_data[`BIT_OUTPUT_CUT] <= output_cut_r;
          end
          `ADDR_MIXER: begin
            rd_data[`BIT_SPK_GAIN] <= spk_gain_r;
            rd_data[`BIT_LHP_MIX] <= lhp_mix_r;
            rd_data[`BIT_RHP_MIX] <= rhp_mix_r;
            rd_data[`BIT_SPK_MIX] <= spk_mix_r;
          end
          `ADDR_ANTIPOP: begin
            rd_data[`BIT_STARTUP_BIAS] <= startup_bias_r;
          end
          `ADDR_SEQ: begin
            rd_data[`BIT_SEQ_ON] <= seq_on_r;
          end
          `ADDR_CPUMP: begin
            rd_data[`BIT_CPUMP_ON] <= cpump_on_r;
          end
          `ADDR_SERVO: begin
            rd_data[`BIT_RSERVO] <= rservo_r;
            rd_data[`BIT_LSERVO] <= lservo_r;
          end
          default: begin
            rd_data <= 16'h0000;
          end
        endcase
      end
    end
  end

  // Enables come straight from their flops, so no decode glitch reaches
  // the analogue switches. The identifier is never stored at all.
  assign temp_sensor_on = sensor_on_r;
  assign speaker_gain_stage_on = spk_gain_r;
  assign speaker_mixer_on = spk_mix_r;
  assign left_headphone_mixer_on = lhp_mix_r;
  assign right_headphone_mixer_on = rhp_mix_r;

  // Bias, sequencer, pump and servo enables.
  assign startup_bias_on = startup_bias_r;
  assign sequencer_on = seq_on_r;
  assign charge_pump_on = cpump_on_r;
  assign right_offset_servo_on = rservo_r;
  assign left_offset_servo_on = lservo_r;
endmodule

// *** src/sync2.v ***
// Two-flop synchroniser for a single level from outside the clock domain.
`timescale 1ns/1ns
module sync2 (
  input wire ref_clk, // System clock.
  input wire sys_rst, // Asynchronous reset, active high.
  input wire d, // Asynchronous level.
  output wire q // Synchronised level.
);
  reg s1_r;
  reg s2_r;
  // First stage feeds only the second stage to keep metastability contained.
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule

// *** verification/power_thermal_reset_ctrl_props.sv ***
// Port checker for the power/thermal register bank.
`timescale 1ns/1ns
module power_thermal_reset_ctrl_props #(parameter [15:0] CHIP_ID = 16'h0000) (
  input wire ref_clk, input wire sys_rst, input wire wr_en, input wire rd_en,
  input wire [7:0] reg_addr, input wire [15:0] wr_data, input wire [15:0] rd_data,
  input wire rd_valid, input wire overtemp_raw, input wire temp_sensor_on,
  input wire speaker_gain_stage_on, input wire speaker_mixer_on,
  input wire left_headphone_mixer_on, input wire right_headphone_mixer_on,
  input wire startup_bias_on, input wire sequencer_on, input wire charge_pump_on,
  input wire right_offset_servo_on, input wire left_offset_servo_on,
  input wire speaker_out_cut, input wire soft_reset_pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Soft reset is a write to the identity word followed by a return to defaults.
  sequence s_id_write; wr_en && reg_addr == 8'h00; endsequence
  sequence s_defaults; temp_sensor_on && !speaker_gain_stage_on && !charge_pump_on
    && !sequencer_on && !startup_bias_on && !left_offset_servo_on; endsequence
  a_read_answer: assert property (rd_en |=> rd_valid) else $error("read not answered");
  a_no_stray_valid: assert property (!rd_en |=> !rd_valid) else $error("stray read valid");
  a_soft_reset: assert property (s_id_write |=> soft_reset_pulse ##0 s_defaults)
    else $error("soft reset missing");
  a_pulse_cause: assert property (!(wr_en && reg_addr == 8'h00) |=> !soft_reset_pulse)
    else $error("stray reset pulse");
  a_id_read: assert property (rd_en && reg_addr == 8'h00 |=> rd_data == CHIP_ID)
    else $error("identity wrong");
  a_mixer_write: assert property (wr_en && reg_addr == 8'h03 |=>
    {speaker_gain_stage_on, left_headphone_mixer_on, right_headphone_mixer_on,
    speaker_mixer_on} == {$past(wr_data[8]), $past(wr_data[5:3])}) else $error("mixer bits");
  a_servo_write: assert property (wr_en && reg_addr == 8'h54 |=>
    {right_offset_servo_on, left_offset_servo_on} == $past(wr_data[1:0])) else $error("servo");
  a_cut_sensor: assert property (speaker_out_cut |-> temp_sensor_on)
    else $error("cut without sensor");
  a_status_read: assert property (rd_en && reg_addr == 8'h02 |=>
    rd_data[14] == $past(temp_sensor_on) && rd_data[15] <= $past(temp_sensor_on))
    else $error("status read");
  a_sensor_write: assert property (wr_en && reg_addr == 8'h02 |=>
    temp_sensor_on == $past(wr_data[14])) else $error("sensor bit");
  a_bias_write: assert property (wr_en && reg_addr == 8'h39 |=>
    startup_bias_on == $past(wr_data[2])) else $error("bias bit");
endmodule
bind power_thermal_reset_ctrl power_thermal_reset_ctrl_props #(.CHIP_ID(CHIP_ID)) props_inst (.*);

// *** verification/power_thermal_reset_ctrl_test.sv ***
// Self-checking bench for the power/thermal register bank.
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module power_thermal_reset_ctrl_test;
  localparam [15:0] ID = 16'h3c3c; // Arbitrary identifier for this run.
  reg ref_clk = 0, sys_rst = 1, wr_en = 0, rd_en = 0, overtemp_raw = 0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] wr_data = 16'h0000, d;
  wire [15:0] rd_data;
  wire rd_valid, temp_sensor_on, speaker_gain_stage_on, speaker_mixer_on, startup_bias_on;
  wire left_headphone_mixer_on, right_headphone_mixer_on, sequencer_on, charge_pump_on;
  wire right_offset_servo_on, left_offset_servo_on, speaker_out_cut, soft_reset_pulse;
  integer num_errors = 0, n_compared = 0, i, j;
  reg [31:0] lf = 32'h00014628;
  reg [7:0] at [0:5];
  reg [15:0] mk [0:5];
  reg [15:0] sh [0:5];
  power_thermal_reset_ctrl #(.CHIP_ID(ID)) power_thermal_reset_ctrl_inst (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .overtemp_raw(overtemp_raw),
    .temp_sensor_on(temp_sensor_on),
    .speaker_gain_stage_on(speaker_gain_stage_on),
    .speaker_mixer_on(speaker_mixer_on),
    .left_headphone_mixer_on(left_headphone_mixer_on),
    .right_headphone_mixer_on(right_headphone_mixer_on),
    .startup_bias_on(startup_bias_on),
    .sequencer_on(sequencer_on),
    .charge_pump_on(charge_pump_on),
    .right_offset_servo_on(right_offset_servo_on),
    .left_offset_servo_on(left_offset_servo_on),
    .speaker_out_cut(speaker_out_cut),
    .soft_reset_pulse(soft_reset_pulse)
  );
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Shift register of the bench; a fixed start keeps runs repeatable.
  function [31:0] nx(input [31:0] x);
    nx = x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction
  // Expected read word: status follows the sensor only while it is enabled.
  function [15:0] er(input integer k);
    er = sh[k] | ((k == 0 && overtemp_raw && sh[0][14]) ? 16'h8000 : 16'h0000);
  endfunction
  task end_sim;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [15:0] v);
    begin
      @(negedge ref_clk);
      wr_en = 1;
      reg_addr = a;
      wr_data = v;
      @(negedge ref_clk);
      wr_en = 0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] m, input [15:0] e);
    integer k;
    begin
      @(negedge ref_clk);
      rd_en = 1;
      reg_addr = a;
      @(negedge ref_clk);
      rd_en = 0;
      for (k = 0; k < 4 && rd_valid !== 1'b1; k++) @(negedge ref_clk);
      if (k == 4) begin
        num_errors++;
        end_sim;
      end else begin
        `CHK(rd_data & m, e)
      end
    end
  endtask
  // Compares every enable and the cut level against the shadow copies.
  task chk_outs;
    begin
      `CHK({temp_sensor_on, speaker_gain_stage_on, speaker_mixer_on, left_headphone_mixer_on, right_headphone_mixer_on, startup_bias_on, sequencer_on, charge_pump_on, right_offset_servo_on, left_offset_servo_on}, {sh[0][14], sh[1][8], sh[1][3], sh[1][5], sh[1][4], sh[2][2], sh[3][8], sh[4][15], sh[5][1], sh[5][0]})
      `CHK(speaker_out_cut, sh[0][14] & sh[0][13] & overtemp_raw)
    end
  endtask
  task defaults;
    begin
      sh[0] = 16'h6000;
      for (j = 1; j < 6; j++) sh[j] = 16'h0000;
    end
  endtask
  initial begin
    // Addresses and writable-bit masks of the six field registers.
    at[0] = 8'h02;
    at[1] = 8'h03;
    at[2] = 8'h39;
    at[3] = 8'h46;
    at[4] = 8'h4c;
    at[5] = 8'h54;
    mk[0] = 16'h6000;
    mk[1] = 16'h0138;
    mk[2] = 16'h0004;
    mk[3] = 16'h0100;
    mk[4] = 16'h8000;
    mk[5] = 16'h0003;
    defaults;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) sys_rst = 0;
    chk_outs;
    for (i = 0; i < 6; i++) rd(at[i], mk[i] | 16'h8000, er(i));
    rd(8'h00, 16'hffff, ID);
    rd(8'h10, 16'hffff, 16'h0000);
    // Random writes; the sensor trips halfway, after the two-flop delay.
    for (i = 0; i < 40; i++) begin
      if (i == 20) begin
        overtemp_raw = 1;
        repeat (3) @(negedge ref_clk);
      end
      lf = nx(lf);
      j = lf % 6;
      d = lf[31:16];
      // mixers off before thermal bits change
      if (j == 0) begin
        wr(at[1], 16'h0000);
        sh[1] = 16'h0000;
      end
      wr(at[j], d);
      sh[j] = d & mk[j];
      chk_outs;
      rd(at[j], mk[j] | 16'h8000, er(j));
    end
    // Writes to an unmapped address are dropped.
    wr(8'h10, 16'hffff);
    chk_outs;
    // Set every field outside register 02h first so the return to defaults is visible.
    for (i = 1; i < 6; i++) begin
      wr(at[i], 16'hffff);
      sh[i] = mk[i];
    end
    chk_outs;
    // Soft reset with a random word; identity must not change.
    wr(8'h00, lf[15:0]);
    `CHK(soft_reset_pulse, 1'b1)
    defaults;
    chk_outs;
    @(negedge ref_clk);
    `CHK(soft_reset_pulse, 1'b0)
    rd(8'h00, 16'hffff, ID);
    end_sim;
  end
endmodule
